// ### design/regulator_enable_mode_ctrl_pkg.sv
// Constants and types of the rail control register bank
`default_nettype none
package regulator_enable_mode_ctrl_pkg;
   // Register offsets on the serial bus
   localparam logic [7:0] ADDR_LIN_A3 = 8'h9B;
   localparam logic [7:0] ADDR_SD_CTRL = 8'h9C;
   localparam logic [7:0] ADDR_FORCE = 8'h9E;
   // Reset values; the linear regulator code is factory dependent
   localparam logic [7:0] LIN_A3_RST = 8'hBB;
   localparam logic [7:0] LIN_A3_RST_ALT = 8'h00;
   localparam logic [7:0] SD_CTRL_RST = 8'h07;
   localparam logic [7:0] SD_CTRL_RST_ALT = 8'h27;
   localparam logic [7:0] FORCE_RST = 8'h00;
   localparam logic [7:0] SD_CTRL_WMASK = 8'h3F;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // Bus address of the device, value arbitrary
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;
   localparam logic [3:0] BIT_LAST = 4'h8;
   // Field positions
   localparam int SD_KILL_LSB = 0;
   localparam int SD_PWM_LSB = 3;
   localparam int A3_NORMAL_LSB = 0;
   localparam int A3_SLEEP_LSB = 4;

   typedef struct packed {
      logic [3:0] lin_a3_sleep_code;
      logic [3:0] lin_a3_normal_code;
   } lin_a3_voltage_t;

   typedef struct packed {
      logic [1:0] reserved;
      logic [2:0] sd_pwm_select;
      logic [2:0] sd_kill_n;
   } stepdown_mode_disable_t;

   typedef struct packed {
      logic lin_a2_force_on;
      logic switch_a1_force_on;
      logic [5:0] sd_force_on;
   } rail_force_enable_t;

   // Pins that come from outside the clock domain
   typedef struct packed {
      logic sleep_state_n;
      logic linear_switch_enable_pin;
      logic switch_enable_pin;
      logic scl;
      logic sda;
   } pin_in_t;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ADDR_ACK = 9'h004,
      ST_PTR = 9'h008,
      ST_PTR_ACK = 9'h010,
      ST_WDATA = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA = 9'h080,
      ST_RDATA_ACK = 9'h100
   } bus_state_t;
endpackage : regulator_enable_mode_ctrl_pkg
`default_nettype wire

// ### design/regulator_enable_mode_ctrl.sv
// Rail control register bank behind an I2C slave port
`default_nettype none
// How it works
// - Upper nibble gives code while sleep low
// - Lower nibble gives code while sleep high
// - Mode bits 3..5: 0 auto, 1 PWM
// - Cleared kill bit forces rail 1..3 off
// - Kill bit overrides force-on bit
// - Force bits 0..5 turn step-down rails on
// - Bit 7 forces regulator two, else pin
// - Bit 6 forces switch, else either pin
// - Force register resets to all zeros
// - Control register resets to 0x07 or variant
// - Voltage register resets to factory value
module regulator_enable_mode_ctrl
   import regulator_enable_mode_ctrl_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
   parameter logic [7:0] A3_RST = LIN_A3_RST,
   parameter logic [7:0] CTRL_RST = SD_CTRL_RST
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic sleep_state_n_i,
   input wire logic linear_switch_enable_pin_i,
   input wire logic switch_enable_pin_i,
   input wire logic [5:0] seq_en_i,
   output logic [3:0] lin_a3_code_o,
   output logic [2:0] sd_pwm_select_o,
   output logic [5:0] sd_on_o,
   output logic lin_a2_on_o,
   output logic switch_a1_on_o
);

   // Reserved bits must be zero in the variant reset value
   if (CTRL_RST[7:6] != 2'b00) begin : g_bad_rst
      $error("control reset value sets reserved bits");
   end
   if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
      $error("bus address lies in a reserved group");
   end

   pin_in_t pins_raw;
   pin_in_t meta_q;
   pin_in_t sync_q;
   pin_in_t dly_q;
   bus_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] sr_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic rw_q;
   logic wr_q;
   lin_a3_voltage_t a3_q;
   stepdown_mode_disable_t ctrl_q;
   rail_force_enable_t force_q;
   logic [7:0] rd_data;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign pins_raw = '{sleep_state_n: sleep_state_n_i, linear_switch_enable_pin: linear_switch_enable_pin_i,
                       switch_enable_pin: switch_enable_pin_i, scl: scl_i, sda: sda_i};

   // Two stages, then a third for edge detection so the first stays private
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= 5'h1F;
         sync_q <= 5'h1F;
         dly_q <= 5'h1F;
      end else begin
         meta_q <= pins_raw;
         sync_q <= meta_q;
         dly_q <= sync_q;
      end
   end

   assign scl_rise = sync_q.scl & ~dly_q.scl;
   assign scl_fall = ~sync_q.scl & dly_q.scl;
   assign bus_start = sync_q.scl & dly_q.scl & dly_q.sda & ~sync_q.sda;
   assign bus_stop = sync_q.scl & dly_q.scl & ~dly_q.sda & sync_q.sda;

   always_comb begin
      unique case (ptr_q)
         ADDR_LIN_A3: rd_data = a3_q;
         ADDR_SD_CTRL: rd_data = ctrl_q;
         ADDR_FORCE: rd_data = force_q;
         default: rd_data = READ_UNMAPPED;
      endcase
   end

   // Bus protocol; only the open-drain low is ever driven
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sr_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         wr_q <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         if (bus_start) begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (bus_stop) begin
            state_q <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            unique case (state_q)
               ST_IDLE: begin
               end
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  if (scl_rise) begin
                     sr_q <= {sr_q[6:0], sync_q.sda};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == BIT_LAST) begin
                     sda_oe_o <= 1'b1;
                     if (state_q == ST_ADDR) begin
                        if (sr_q[7:1] == DEV_ADDR) begin
                           rw_q <= sr_q[0];
                           state_q <= ST_ADDR_ACK;
                        end else begin
                           sda_oe_o <= 1'b0;
                           state_q <= ST_IDLE;
                        end
                     end else if (state_q == ST_PTR) begin
                        ptr_q <= sr_q;
                        state_q <= ST_PTR_ACK;
                     end else begin
                        wr_q <= 1'b1;
                        state_q <= ST_WDATA_ACK;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     cnt_q <= 4'h0;
                     if (rw_q) begin
                        tx_q <= rd_data;
                        sda_oe_o <= ~rd_data[7];
                        state_q <= ST_RDATA;
                     end else begin
                        sda_oe_o <= 1'b0;
                        state_q <= ST_PTR;
                     end
                  end
               end
               ST_PTR_ACK, ST_WDATA_ACK: begin
                  if (scl_fall) begin
                     sda_oe_o <= 1'b0;
                     cnt_q <= 4'h0;
                     if (state_q == ST_WDATA_ACK) begin
                        ptr_q <= ptr_q + 8'h01;
                     end
                     state_q <= ST_WDATA;
                  end
               end
               ST_RDATA: begin
                  if (scl_rise) begin
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt_q == BIT_LAST) begin
                        sda_oe_o <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                        state_q <= ST_RDATA_ACK;
                     end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_o <= ~tx_q[6];
                     end
                  end
               end
               ST_RDATA_ACK: begin
                  // A host NACK ends the read; wait for stop or restart
                  if (scl_rise && sync_q.sda) begin
                     state_q <= ST_IDLE;
                  end else if (scl_fall) begin
                     cnt_q <= 4'h0;
                     tx_q <= rd_data;
                     sda_oe_o <= ~rd_data[7];
                     state_q <= ST_RDATA;
                  end
               end
            endcase
         end
      end
   end

   assign sda_o = 1'b0;

   // Register file; writes to other offsets are acknowledged and dropped
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a3_q <= A3_RST;
         ctrl_q <= CTRL_RST & SD_CTRL_WMASK;
         force_q <= FORCE_RST;
      end else if (wr_q) begin
         if (ptr_q == ADDR_LIN_A3) begin
            a3_q <= sr_q;
         end
         if (ptr_q == ADDR_SD_CTRL) begin
            ctrl_q <= sr_q & SD_CTRL_WMASK;
         end
         if (ptr_q == ADDR_FORCE) begin
            force_q <= sr_q;
         end
      end
   end

   // Rail controls, registered so every output comes from a flop
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lin_a3_code_o <= 4'h0;
         sd_pwm_select_o <= 3'h0;
         sd_on_o <= 6'h00;
         lin_a2_on_o <= 1'b0;
         switch_a1_on_o <= 1'b0;
      end else begin
         lin_a3_code_o <= sync_q.sleep_state_n ? a3_q.lin_a3_normal_code
                                               : a3_q.lin_a3_sleep_code;
         sd_pwm_select_o <= ctrl_q.sd_pwm_select;
         sd_on_o[5:3] <= force_q.sd_force_on[5:3] | seq_en_i[5:3];
         sd_on_o[2:0] <= ctrl_q.sd_kill_n & (force_q.sd_force_on[2:0] | seq_en_i[2:0]);
         lin_a2_on_o <= force_q.lin_a2_force_on | sync_q.linear_switch_enable_pin;
         switch_a1_on_o <= force_q.switch_a1_force_on | sync_q.linear_switch_enable_pin
                           | sync_q.switch_enable_pin;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   a_sleep_code_sel: assert property (!sync_q.sleep_state_n |=> lin_a3_code_o == $past(a3_q[7:4]))
      else $error("sleep code not applied");
   a_normal_code_sel: assert property (sync_q.sleep_state_n |=> lin_a3_code_o == $past(a3_q[3:0]))
      else $error("normal code not applied");
   a_pwm_mode_out: assert property (##1 sd_pwm_select_o == $past(sr_q[5:3], 2) || !$past(wr_q, 2)
      || $past(ptr_q, 2) != ADDR_SD_CTRL)
      else $error("mode bits not forwarded");
   a_kill_forces_off: assert property (1'b1 |=> (sd_on_o[2:0] & ~$past(ctrl_q.sd_kill_n)) == 3'h0)
      else $error("killed rail is on");
   a_force_turns_on: assert property (1'b1 |=>
      (sd_on_o[5:3] & $past(force_q.sd_force_on[5:3])) == $past(force_q.sd_force_on[5:3]))
      else $error("forced rail not on");
   a_lin_a2_enable: assert property (1'b1 |=>
      lin_a2_on_o == $past(force_q.lin_a2_force_on | sync_q.linear_switch_enable_pin))
      else $error("regulator two enable wrong");
   a_switch_enable: assert property (!force_q.switch_a1_force_on && !sync_q.linear_switch_enable_pin
      && !sync_q.switch_enable_pin |=> !switch_a1_on_o)
      else $error("switch on without cause");
   a_ctrl_write_mask: assert property (wr_q && ptr_q == ADDR_SD_CTRL |=>
      ctrl_q == {2'b00, $past(sr_q[5:0])})
      else $error("control write mishandled");
   // Second clock edge in reset: the first one may see the flops before any reset edge has reached them
   a_force_reset: assert property (disable iff (1'b0) !rst_n_i ##1 !rst_n_i |-> force_q == FORCE_RST)
      else $error("force register not cleared");

   sequence s_addr_match;
      state_q == ST_ADDR && scl_fall && cnt_q == BIT_LAST && sr_q[7:1] == DEV_ADDR && !bus_start && !bus_stop;
   endsequence
   sequence s_ack_driven;
      sda_oe_o && state_q == ST_ADDR_ACK;
   endsequence
   a_addr_ack: assert property (s_addr_match |=> s_ack_driven)
      else $error("address not acknowledged");

endmodule : regulator_enable_mode_ctrl
`default_nettype wire

// ### verification/i2c_host_model.sv
// I2C host model that programs the rail control bank
`default_nettype none
module i2c_host_model
   import regulator_enable_mode_ctrl_pkg::*;
(
   input wire logic clk_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rel_q = 1'b1;
   int ph = 4;
   // Pull-up: released wire reads high, never the last value
   assign sda_o = rel_q & ~sda_oe_i;
   initial scl_o = 1'b1;
   task automatic hold();
      repeat (ph) @(posedge clk_i);
   endtask
   // Data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      rel_q <= b;
      hold();
      scl_o <= 1'b1;
      hold();
      r = sda_o;
      hold();
      scl_o <= 1'b0;
      hold();
   endtask
   task automatic start();
      rel_q <= 1'b1;
      hold();
      scl_o <= 1'b1;
      hold();
      rel_q <= 1'b0;
      hold();
      scl_o <= 1'b0;
      hold();
   endtask
   task automatic stop();
      rel_q <= 1'b0;
      hold();
      scl_o <= 1'b1;
      hold();
      rel_q <= 1'b1;
      hold();
   endtask
   task automatic tx(input logic [7:0] b, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ok = ~r;
   endtask
   task automatic rx(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, r);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d[$], output logic ok);
      logic a;
      start();
      tx({DEV_ADDR_DEF, 1'b0}, ok);
      tx(p, a);
      ok = ok & a;
      foreach (d[i]) begin
         tx(d[i], a);
         ok = ok & a;
      end
      stop();
   endtask
   task automatic rd(input logic [7:0] p, input int n, output logic [7:0] q[$], output logic ok);
      logic a;
      logic [7:0] v;
      q = {};
      start();
      tx({DEV_ADDR_DEF, 1'b0}, ok);
      tx(p, a);
      ok = ok & a;
      start();
      tx({DEV_ADDR_DEF, 1'b1}, a);
      ok = ok & a;
      for (int i = 0; i < n; i++) begin
         rx(i == n - 1, v);
         q.push_back(v);
      end
      stop();
   endtask
endmodule // i2c_host_model
`default_nettype wire

// ### verification/regulator_enable_mode_ctrl_bench.sv
// Self-checking bench of the rail control register bank
`default_nettype none
module regulator_enable_mode_ctrl_bench
   import regulator_enable_mode_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sleep_n = 1'b1;
   logic lin_pin = 1'b0;
   logic sw_pin = 1'b0;
   logic [5:0] seq_en = 6'h00;
   logic scl, sda, sda_oe, a2_on, a1_on;
   logic [3:0] code;
   logic [2:0] pwm;
   logic [5:0] on;
   int n_fail = 0;
   int checked = 0;
   initial forever #12.5 clk = ~clk;
   i2c_host_model host (.clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
   regulator_enable_mode_ctrl dut (.clk_sys_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_o(sda_oe), .sleep_state_n_i(sleep_n), .linear_switch_enable_pin_i(lin_pin),
      .switch_enable_pin_i(sw_pin), .seq_en_i(seq_en), .lin_a3_code_o(code), .sd_pwm_select_o(pwm),
      .sd_on_o(on), .lin_a2_on_o(a2_on), .switch_a1_on_o(a1_on));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
      logic ok;
      host.wr(p, d, ok);
      chk("write ack", 8'h01, {7'h00, ok});
      repeat (4) @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] p, input logic [7:0] e[$]);
      logic ok;
      logic [7:0] q[$];
      host.rd(p, e.size(), q, ok);
      chk("read ack", 8'h01, {7'h00, ok});
      foreach (e[i]) chk("read data", e[i], q[i]);
   endtask
   // Pins pass a two-flop synchroniser, so allow a few clocks
   task automatic pins(input logic lp, input logic sp, input logic sn, input logic [5:0] se);
      @(posedge clk);
      lin_pin <= lp;
      sw_pin <= sp;
      sleep_n <= sn;
      seq_en <= se;
      repeat (5) @(posedge clk);
   endtask
   task automatic t_reset();
      pins(1'b0, 1'b0, 1'b1, 6'h00);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk("normal code", 8'h0B, {4'h0, code});
      chk("pwm", 8'h00, {5'h00, pwm});
      chk("rail on", 8'h00, {2'b00, on});
      rd_chk(ADDR_LIN_A3, '{8'hBB, 8'h07, 8'h00, 8'h00});
   endtask
   task automatic t_badaddr();
      logic ok;
      host.start();
      host.tx({DEV_ADDR_DEF ^ 7'h01, 1'b0}, ok);
      host.stop();
      chk("foreign ack", 8'h00, {7'h00, ok});
   endtask
   task automatic t_voltage();
      wr(ADDR_LIN_A3, '{8'h5A});
      chk("normal code", 8'h0A, {4'h0, code});
      pins(1'b0, 1'b0, 1'b0, 6'h00);
      chk("sleep code", 8'h05, {4'h0, code});
      wr(ADDR_LIN_A3, '{8'h33});
      chk("sleep code", 8'h03, {4'h0, code});
      pins(1'b0, 1'b0, 1'b1, 6'h00);
      chk("normal code", 8'h03, {4'h0, code});
   endtask
   task automatic t_ctrl();
      // Slow host: burst crosses the unmapped hole between registers
      host.ph = 10;
      wr(ADDR_SD_CTRL, '{8'hFF, 8'h77, 8'hFF});
      host.ph = 4;
      chk("pwm", 8'h07, {5'h00, pwm});
      chk("rail on", 8'h3F, {2'b00, on});
      rd_chk(ADDR_SD_CTRL, '{8'h3F, 8'h00, 8'hFF});
      wr(ADDR_SD_CTRL, '{8'h2A});
      chk("pwm", 8'h05, {5'h00, pwm});
      chk("rail on", 8'h3A, {2'b00, on});
      wr(ADDR_FORCE, '{8'h00});
      pins(1'b1, 1'b1, 1'b1, 6'h05);
      chk("rail on", 8'h00, {2'b00, on});
   endtask
   task automatic t_force();
      logic [7:0] f;
      wr(ADDR_SD_CTRL, '{8'h07});
      pins(1'b0, 1'b0, 1'b1, 6'h2A);
      chk("rail on", 8'h2A, {2'b00, on});
      for (int k = 0; k < 2; k++) begin
         f = (k == 1) ? 8'hC0 : 8'h00;
         wr(ADDR_FORCE, '{f});
         for (int p = 0; p < 4; p++) begin
            pins(p[1], p[0], 1'b1, 6'h00);
            chk("reg two on", {7'h00, f[7] | p[1]}, {7'h00, a2_on});
            chk("switch on", {7'h00, f[6] | p[1] | p[0]}, {7'h00, a1_on});
         end
      end
   endtask
   initial begin
      t_reset();
      t_badaddr();
      t_voltage();
      t_ctrl();
      t_force();
      t_reset();
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      $display("FAIL watchdog expected done seen hang");
      end_sim();
   end
endmodule // regulator_enable_mode_ctrl_bench
`default_nettype wire
